// ===== logic/qadc_pkg.sv
// Shared constants, types and helpers for the quad converter serial link.
package qadc_pkg;
  localparam int QADC_NCH = 4;
  localparam int QADC_W   = 8;
  localparam int CLK_NS   = 100;

  // Serial timing: four aclk cycles per lane bit, eight bits per frame.
  localparam logic [1:0] PH_LAST  = 2'h3;
  localparam logic [1:0] PH_LOAD  = 2'h0;
  localparam logic [1:0] PH_BCLK  = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_MSB  = 3'h0;
  localparam logic [2:0] FRAME_HI = 3'h4;

  // Settling and wake-up times.
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int PD_WAKE_NS    = 375000;
  localparam int STBY_WAKE_NS  = 600;
  localparam int RELOCK_MIN_CYC = (RELOCK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RELOCK_MAX_CYC = (RELOCK_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_WAKE_CYC    = (PD_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STBY_WAKE_CYC  = (STBY_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] RELOCK_DEV_CNT = CNT_W'(RELOCK_MIN_CYC);
  localparam logic [CNT_W-1:0] RELOCK_WAIT_CNT = CNT_W'(RELOCK_MAX_CYC);
  localparam logic [CNT_W-1:0] PD_WAKE_CNT = CNT_W'(PD_WAKE_CYC);
  localparam logic [CNT_W-1:0] STBY_WAKE_CNT = CNT_W'(STBY_WAKE_CYC);

  // Sample rates in MSPS.
  localparam logic [7:0] DCS_MIN_MHZ  = 8'h14;
  localparam logic [7:0] RATE_MIN     = 8'h0a;
  localparam logic [7:0] RATE_MIN_LOW = 8'h05;
  localparam logic [7:0] RATE_MAX     = 8'h64;
  localparam logic [7:0] RATE_RST     = 8'h64;

  typedef struct packed {
    logic [3:0] chan_pd;
    logic       pll_low_rate;
    logic       low_swing;
    logic       standby;
    logic       twos_comp;
    logic       dcs_enable;
  } qadc_cfg_s;

  localparam qadc_cfg_s CFG_RST = '{4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  // Control register fields and register map.
  localparam int CTRL_PD     = 0;
  localparam int CTRL_DCS    = 1;
  localparam int CTRL_TWOS   = 2;
  localparam int CTRL_STBY   = 3;
  localparam int CTRL_LOWSW  = 4;
  localparam int CTRL_PLLLOW = 5;
  localparam int CTRL_ODM    = 6;
  localparam int CTRL_CHPD   = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam int STAT_READY = 0;
  localparam int STAT_ALIGN = 1;
  localparam int STAT_WAIT  = 2;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RATE   = 8'h0c;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Offset binary is the native code; twos complement flips the top bit.
  function automatic logic [QADC_W-1:0] qadc_code(
    input logic [QADC_W-1:0] s,
    input logic              twos);
    qadc_code = twos ? {~s[QADC_W-1], s[QADC_W-2:0]} : s;
  endfunction

  function automatic logic [31:0] qadc_wmask(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb);
    qadc_wmask = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        qadc_wmask[b*8 +: 8] = data[b*8 +: 8];
      end
    end
  endfunction
endpackage

// ===== logic/qadc_if.sv
// Link between the converter end and the receiver end.
`timescale 1ns/1ps
interface qadc_if;
  logic                power_down_pin;
  logic                serial_io_output_mode_pin;
  qadc_pkg::qadc_cfg_s cfg;
  logic [7:0]          sample_rate;
  logic                bit_clock_out;
  logic                byte_frame_clock_out;
  logic [3:0]          lane;
  logic                link_oe;
  logic                low_swing;

  modport dev (
    input  power_down_pin, serial_io_output_mode_pin, cfg, sample_rate,
    output bit_clock_out, byte_frame_clock_out, lane, link_oe, low_swing
  );
  modport rcv (
    output power_down_pin, serial_io_output_mode_pin, cfg, sample_rate,
    input  bit_clock_out, byte_frame_clock_out, lane, link_oe, low_swing
  );
endinterface

// ===== logic/qadc_device.sv
// Converter end: power control, stabilizer lock, coding and serializer.
// Behaviour
// RULE1 - Stabilizer on gives nominal half-period duty.
// RULE2 - Stabilizer can be switched off by configuration.
// RULE3 - Stabilizer inactive below twenty MHz sample rate.
// RULE4 - Relock takes 1.5 to 5 us after change.
// RULE5 - Unlocked stabilizer is bypassed until relock.
// RULE6 - Power-down pin high powers down; low resumes.
// RULE7 - Outputs high impedance during pin power-down.
// RULE8 - Configuration survives power-down without reset.
// RULE9 - Leaving power-down needs about 375 us.
// RULE10 - Each channel powers down individually.
// RULE11 - Standby keeps multiplier running, 600 ns wake.
// RULE12 - Reduced swing by mode pin or setting.
// RULE13 - Offset binary default; twos complement selectable.
// RULE14 - Offset binary code points as tabulated.
// RULE15 - Each converter has its own lane.
// RULE16 - Eight bits per sample period per lane.
// RULE17 - Low-rate setting extends minimum to 5 MSPS.
// RULE18 - Bit clock at four times sample rate.
// RULE19 - Frame clock marks start of each byte.
// RULE20 - Most significant bit sent first.
// RULE21 - Twos complement inverts only the top bit.
`timescale 1ns/1ps
module qadc_device import qadc_pkg::*; (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Link to the receiver
  qadc_if.dev                             link,
  // Converter samples, channel 0 in the low byte
  input  wire logic [QADC_NCH*QADC_W-1:0] sample_in,
  // Status
  output logic                            sample_taken,
  output logic                            duty_stabilized,
  output logic                            dcs_relocking,
  output logic                            awake,
  output logic                            rate_ok
);
  localparam int SW = 2 + 8 + $bits(qadc_cfg_s);

  typedef enum logic [3:0] {
    ST_DOWN = 4'b0001,
    ST_WAKE = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_STBY = 4'b1000
  } qadc_pwr_e;

  logic [SW-1:0]    sync1;
  logic [SW-1:0]    sync2;
  logic             pd_s;
  logic             odm_s;
  logic [7:0]       rate_s;
  qadc_cfg_s        cfg_s;

  qadc_pwr_e        state;
  qadc_pwr_e        next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  qadc_cfg_s        cfg_q;
  qadc_cfg_s        next_cfg;
  logic [7:0]       rate_q;
  logic [7:0]       next_rate;
  logic [CNT_W-1:0] dcs_cnt;
  logic [CNT_W-1:0] next_dcs_cnt;
  logic [1:0]       ph;
  logic [1:0]       next_ph;
  logic [2:0]       bitn;
  logic [2:0]       next_bitn;
  logic [7:0]       sh [QADC_NCH];
  logic [7:0]       next_sh [QADC_NCH];
  logic [3:0]       lane_q;
  logic [3:0]       next_lane;
  logic             bclk_q;
  logic             next_bclk;
  logic             fclk_q;
  logic             next_fclk;
  logic             oe_q;
  logic             next_oe;
  logic             lowsw_q;
  logic             next_lowsw;
  logic             next_taken;
  logic             next_stab;
  logic             next_relock;
  logic             next_awake;
  logic             next_rate_ok;
  logic             below_min;

  // Pins from the far party cross in through two flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {link.power_down_pin, link.serial_io_output_mode_pin,
                link.sample_rate, link.cfg};
      sync2 <= sync1;
    end
  end

  assign pd_s   = sync2[SW-1];
  assign odm_s  = sync2[SW-2];
  assign rate_s = sync2[SW-3 -: 8];
  assign cfg_s  = qadc_cfg_s'(sync2[$bits(qadc_cfg_s)-1:0]);

  always_comb begin
    logic [7:0] src;
    src          = '0;
    next_state   = state;
    next_cnt     = cnt;
    next_cfg     = cfg_q;
    next_rate    = rate_s;
    next_dcs_cnt = dcs_cnt;
    next_ph      = '0;
    next_bitn    = '0;
    next_sh      = sh;
    next_lane    = '0;
    next_bclk    = 1'b0;
    next_fclk    = 1'b0;
    next_taken   = 1'b0;
    below_min    = rate_q < DCS_MIN_MHZ;

    // RULE8 config held while down
    if (state != ST_DOWN) begin
      next_cfg = cfg_s;
    end

    unique case (state)
      ST_DOWN: begin
        // RULE9 full restart on exit
        if (!pd_s) begin
          next_state = ST_WAKE;
          next_cnt   = PD_WAKE_CNT;
        end
      end
      ST_WAKE: begin
        if (cnt == '0) begin
          next_state = ST_RUN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_RUN: begin
        if (cfg_q.standby) begin
          next_state = ST_STBY;
        end
      end
      ST_STBY: begin
        // RULE11 short standby wake
        if (!cfg_q.standby) begin
          next_state = ST_WAKE;
          next_cnt   = STBY_WAKE_CNT;
        end
      end
    endcase
    // RULE6 pin forces power-down
    if (pd_s) begin
      next_state = ST_DOWN;
    end

    // RULE4 relock after rate change
    if (state == ST_DOWN || rate_s != rate_q ||
        (cfg_s.dcs_enable && !cfg_q.dcs_enable)) begin
      next_dcs_cnt = RELOCK_DEV_CNT;
    end else if (dcs_cnt != '0 && !below_min) begin
      next_dcs_cnt = dcs_cnt - 1'b1;
    end
    // RULE1 stabilized timing when locked
    // RULE2 disable selects raw clock
    // RULE3 no loop below minimum
    next_stab   = cfg_q.dcs_enable && !below_min && dcs_cnt == '0;
    // RULE5 bypass while relocking
    next_relock = cfg_q.dcs_enable && !below_min && dcs_cnt != '0;

    // RULE17 low-rate extension
    next_rate_ok = rate_q <= RATE_MAX &&
                   rate_q >= (cfg_q.pll_low_rate ? RATE_MIN_LOW : RATE_MIN);

    // RULE12 reduced swing select
    next_lowsw = odm_s | cfg_q.low_swing;
    // RULE7 drivers released while down
    next_oe    = next_state != ST_DOWN;
    next_awake = next_state == ST_RUN;

    // Lanes idle low in standby and wake-up so the far end sees no edges.
    if (state == ST_RUN) begin
      next_ph   = ph + 1'b1;
      next_bitn = (ph == PH_LAST) ? bitn + 1'b1 : bitn;
      next_lane = lane_q;
      next_bclk = bclk_q;
      next_fclk = fclk_q;
      // RULE18 bit clock toggles mid-bit
      if (ph == PH_BCLK) begin
        next_bclk = ~bclk_q;
      end
      if (ph == PH_LOAD) begin
        // RULE19 frame high for first half
        next_fclk  = bitn < FRAME_HI;
        next_taken = bitn == BIT_MSB;
        // RULE15 one lane per converter
        for (int i = 0; i < QADC_NCH; i++) begin
          if (bitn == BIT_MSB) begin
            // RULE10 channel power-down zeroes lane
            // RULE13 coding select
            // RULE14 offset binary passes through
            // RULE21 twos flips top bit
            src = cfg_q.chan_pd[i] ? '0 :
                  qadc_code(sample_in[i*QADC_W +: QADC_W],
                            cfg_q.twos_comp);
          end else begin
            src = {sh[i][6:0], 1'b0};
          end
          // RULE16 eight bits per frame
          // RULE20 top bit goes out first
          next_sh[i]   = src;
          next_lane[i] = src[QADC_W-1];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state           <= ST_DOWN;
      cnt             <= '0;
      cfg_q           <= CFG_RST;
      rate_q          <= RATE_RST;
      dcs_cnt         <= RELOCK_DEV_CNT;
      ph              <= '0;
      bitn            <= '0;
      sh              <= '{default: '0};
      lane_q          <= '0;
      bclk_q          <= 1'b0;
      fclk_q          <= 1'b0;
      oe_q            <= 1'b0;
      lowsw_q         <= 1'b0;
      sample_taken    <= 1'b0;
      duty_stabilized <= 1'b0;
      dcs_relocking   <= 1'b0;
      awake           <= 1'b0;
      rate_ok         <= 1'b0;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      cfg_q           <= next_cfg;
      rate_q          <= next_rate;
      dcs_cnt         <= next_dcs_cnt;
      ph              <= next_ph;
      bitn            <= next_bitn;
      sh              <= next_sh;
      lane_q          <= next_lane;
      bclk_q          <= next_bclk;
      fclk_q          <= next_fclk;
      oe_q            <= next_oe;
      lowsw_q         <= next_lowsw;
      sample_taken    <= next_taken;
      duty_stabilized <= next_stab;
      dcs_relocking   <= next_relock;
      awake           <= next_awake;
      rate_ok         <= next_rate_ok;
    end
  end

  assign link.lane                 = lane_q;
  assign link.bit_clock_out        = bclk_q;
  assign link.byte_frame_clock_out = fclk_q;
  assign link.link_oe              = oe_q;
  assign link.low_swing            = lowsw_q;
endmodule

// ===== logic/qadc_receiver.sv
// Receiver end: AXI4-Lite control registers and lane capture.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module qadc_receiver import qadc_pkg::*; (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Link to the converter
  qadc_if.rcv                    link,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Captured samples, channel 0 in the low byte
  output logic [31:0]            sample_word,
  output logic                   sample_valid,
  output logic                   link_ready
);
  logic [5:0]        sync1;
  logic [5:0]        sync2;
  logic [31:0]       ctrl;
  logic [31:0]       next_ctrl;
  logic [7:0]        rate;
  logic [7:0]        next_rate;
  logic              aw_full;
  logic              next_aw_full;
  logic              w_full;
  logic              next_w_full;
  logic [ADDR_W-1:0] aw_q;
  logic [ADDR_W-1:0] next_aw_q;
  logic [31:0]       wd_q;
  logic [31:0]       next_wd_q;
  logic [3:0]        ws_q;
  logic [3:0]        next_ws_q;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;
  logic              bprev;
  logic              fprev;
  logic [2:0]        cnt;
  logic [2:0]        next_cnt;
  logic [7:0]        sh [QADC_NCH];
  logic [7:0]        next_sh [QADC_NCH];
  logic              aligned;
  logic              next_aligned;
  logic [CNT_W-1:0]  wait_cnt;
  logic [CNT_W-1:0]  next_wait;
  logic [31:0]       next_word;
  logic              next_valid;
  logic              next_ready;

  // Link clocks and lanes arrive from outside and pass two flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {link.bit_clock_out, link.byte_frame_clock_out, link.lane};
      sync2 <= sync1;
    end
  end

  always_comb begin
    logic [31:0] status;
    status       = '0;
    next_ctrl    = ctrl;
    next_rate    = rate;
    next_aw_full = aw_full | (awvalid & awready);
    next_w_full  = w_full | (wvalid & wready);
    next_aw_q    = (awvalid & awready) ? awaddr : aw_q;
    next_wd_q    = (wvalid & wready) ? wdata : wd_q;
    next_ws_q    = (wvalid & wready) ? wstrb : ws_q;
    next_bresp   = bresp;
    next_bvalid  = bvalid & ~bready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_rvalid  = rvalid & ~rready;
    next_wait    = (wait_cnt != '0) ? wait_cnt - 1'b1 : wait_cnt;

    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_q)
        OFS_CTRL: next_ctrl = qadc_wmask(ctrl, wd_q, ws_q);
        OFS_RATE: begin
          next_rate = 8'(qadc_wmask({24'h0, rate}, wd_q, ws_q));
          // RULE4 wait out the relock
          if (next_wait < RELOCK_WAIT_CNT) begin
            next_wait = RELOCK_WAIT_CNT;
          end
        end
        OFS_STATUS, OFS_DATA: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // RULE9 allow full recovery time
    if (ctrl[CTRL_PD] && !next_ctrl[CTRL_PD]) begin
      next_wait = PD_WAKE_CNT;
    end

    status[STAT_READY] = link_ready;
    status[STAT_ALIGN] = aligned;
    status[STAT_WAIT]  = wait_cnt != '0;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (araddr)
        OFS_CTRL:   next_rdata = ctrl;
        OFS_STATUS: next_rdata = status;
        OFS_DATA:   next_rdata = sample_word;
        OFS_RATE:   next_rdata = {24'h0, rate};
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    next_cnt     = cnt;
    next_sh      = sh;
    next_aligned = aligned;
    next_word    = sample_word;
    next_valid   = 1'b0;
    if (ctrl[CTRL_PD]) begin
      next_aligned = 1'b0;
      next_cnt     = '0;
    end else if (sync2[4] && !fprev) begin
      // RULE19 frame rise sets byte start
      next_aligned = 1'b1;
      next_cnt     = '0;
    end else if (sync2[5] != bprev) begin
      // RULE18 capture on both edges
      // RULE16 eight bits per sample
      next_cnt = cnt + 1'b1;
      for (int i = 0; i < QADC_NCH; i++) begin
        next_sh[i] = {sh[i][6:0], sync2[i]};
        next_word[i*QADC_W +: QADC_W] = next_sh[i];
      end
      next_valid = aligned && cnt == BIT_LAST;
      if (!next_valid) begin
        next_word = sample_word;
      end
    end
    next_ready = aligned && wait_cnt == '0 && !ctrl[CTRL_PD];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= CTRL_RST;
      rate         <= RATE_RST;
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_q         <= '0;
      wd_q         <= '0;
      ws_q         <= '0;
      awready      <= 1'b0;
      wready       <= 1'b0;
      bresp        <= RESP_OKAY;
      bvalid       <= 1'b0;
      arready      <= 1'b0;
      rdata        <= '0;
      rresp        <= RESP_OKAY;
      rvalid       <= 1'b0;
      bprev        <= 1'b0;
      fprev        <= 1'b0;
      cnt          <= '0;
      sh           <= '{default: '0};
      aligned      <= 1'b0;
      wait_cnt     <= PD_WAKE_CNT;
      sample_word  <= '0;
      sample_valid <= 1'b0;
      link_ready   <= 1'b0;
    end else begin
      ctrl         <= next_ctrl;
      rate         <= next_rate;
      aw_full      <= next_aw_full;
      w_full       <= next_w_full;
      aw_q         <= next_aw_q;
      wd_q         <= next_wd_q;
      ws_q         <= next_ws_q;
      awready      <= ~next_aw_full;
      wready       <= ~next_w_full;
      bresp        <= next_bresp;
      bvalid       <= next_bvalid;
      arready      <= ~next_rvalid;
      rdata        <= next_rdata;
      rresp        <= next_rresp;
      rvalid       <= next_rvalid;
      bprev        <= sync2[5];
      fprev        <= sync2[4];
      cnt          <= next_cnt;
      sh           <= next_sh;
      aligned      <= next_aligned;
      wait_cnt     <= next_wait;
      sample_word  <= next_word;
      sample_valid <= next_valid;
      link_ready   <= next_ready;
    end
  end

  // RULE6 pin level owned here
  assign link.power_down_pin            = ctrl[CTRL_PD];
  assign link.serial_io_output_mode_pin = ctrl[CTRL_ODM];
  assign link.sample_rate               = rate;
  assign link.cfg = '{ctrl[CTRL_CHPD +: 4], ctrl[CTRL_PLLLOW],
                      ctrl[CTRL_LOWSW], ctrl[CTRL_STBY],
                      ctrl[CTRL_TWOS], ctrl[CTRL_DCS]};
endmodule

// ===== tb/qadc_monitor.sv
// Concurrent checks on the link between the converter and receiver ends.
`timescale 1ns/1ps
module qadc_monitor import qadc_pkg::*; (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Controls from the receiver end
  input wire logic       power_down_pin,
  input wire logic       serial_io_output_mode_pin,
  input wire qadc_cfg_s  cfg,
  // Serial side from the converter end
  input wire logic       bit_clock_out,
  input wire logic       byte_frame_clock_out,
  input wire logic [3:0] lane,
  input wire logic       link_oe,
  input wire logic       low_swing
);
  localparam int WAKE = PD_WAKE_CYC;
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] next_wake_cnt;
  logic             quiet;
  logic             swing_req;
  // Lanes stop abruptly in power-down and standby, so framing checks rest.
  assign quiet     = !aresetn || power_down_pin || cfg.standby;
  assign swing_req = serial_io_output_mode_pin || cfg.low_swing;
  always_comb begin
    next_wake_cnt = wake_cnt;
    if (power_down_pin) begin
      next_wake_cnt = '0;
    end else if (wake_cnt != '1) begin
      next_wake_cnt = wake_cnt + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt <= '0;
    end else begin
      wake_cnt <= next_wake_cnt;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_pd_hiz;
    power_down_pin [*6] |-> !link_oe && lane == 4'h0;
  endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("link driven in pd");
  property p_swing;
    (link_oe && $stable(swing_req)) [*6] |-> low_swing == swing_req;
  endproperty
  a_swing: assert property (p_swing) else $error("swing mode wrong");
  property p_frame;
    disable iff (quiet) $rose(byte_frame_clock_out) |-> ##15
      byte_frame_clock_out ##1 !byte_frame_clock_out ##15
      !byte_frame_clock_out ##1 byte_frame_clock_out;
  endproperty
  a_frame: assert property (p_frame) else $error("frame shape wrong");
  property p_bclk;
    disable iff (quiet) $changed(bit_clock_out) |=>
      $stable(bit_clock_out) [*3] ##1 $changed(bit_clock_out);
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock period");
  property p_phase;
    disable iff (quiet) $rose(byte_frame_clock_out) |->
      $stable(bit_clock_out) ##2 $changed(bit_clock_out);
  endproperty
  a_phase: assert property (p_phase) else $error("frame phase wrong");
  property p_lane;
    disable iff (quiet) $changed(lane) |->
      $stable(bit_clock_out) ##2 $changed(bit_clock_out);
  endproperty
  a_lane: assert property (p_lane) else $error("lane bit timing");
  property p_chpd;
    $rose(cfg.chan_pd[2]) |-> ##40 !lane[2];
  endproperty
  a_chpd: assert property (p_chpd) else $error("channel not off");
  property p_wake;
    disable iff (!aresetn || power_down_pin)
      $rose(byte_frame_clock_out) |-> wake_cnt >= WAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("woke too early");
  property p_stby;
    disable iff (!aresetn || power_down_pin)
      $fell(cfg.standby) |-> ##[6:40] $rose(byte_frame_clock_out);
  endproperty
  a_stby: assert property (p_stby) else $error("standby wake slow");
  c_pd: cover property ($fell(power_down_pin));
  c_stby: cover property ($fell(cfg.standby));
  c_chpd: cover property ($rose(cfg.chan_pd[2]));
endmodule

// ===== tb/tb.sv
// Bench joining converter and receiver ends, driven over AXI4-Lite.
`timescale 1ns/1ps
module tb import qadc_pkg::*;;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rsp;
  logic [31:0]       rdata, rd, sample_word;
  logic              sample_valid, link_ready, duty_stabilized, rate_ok;
  logic              dcs_relocking;
  logic [31:0]       sample_in = 32'h007f80ff;
  int                n_fail = 0;
  int                n_compared = 0;
  qadc_if link_if ();
  qadc_device qadc_device_i (.aclk, .aresetn, .link(link_if), .sample_in,
    .sample_taken(), .duty_stabilized, .dcs_relocking, .awake(), .rate_ok);
  qadc_receiver qadc_receiver_i (.aclk, .aresetn, .link(link_if), .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sample_word, .sample_valid, .link_ready);
  qadc_monitor qadc_monitor_i (.aclk, .aresetn,
    .power_down_pin(link_if.power_down_pin),
    .serial_io_output_mode_pin(link_if.serial_io_output_mode_pin),
    .cfg(link_if.cfg), .bit_clock_out(link_if.bit_clock_out),
    .byte_frame_clock_out(link_if.byte_frame_clock_out),
    .lane(link_if.lane), .link_oe(link_if.link_oe),
    .low_swing(link_if.low_swing));
  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stall();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rsp = bresp;
    if (i == 100) stall();
  endtask
  task automatic rdr(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    if (i == 100) stall();
  endtask
  // Up to two words after a change may predate it, so one more is awaited.
  task automatic smp(input int n);
    int i;
    n++;
    for (i = 0; i < 9000 && n > 0; i++) begin
      @(posedge aclk);
      if (sample_valid) n--;
    end
    if (n > 0) stall();
  endtask
  initial begin
    forever #50 aclk = ~aclk;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(OFS_CTRL);
    chk(rd, CTRL_RST);
    rdr(OFS_RATE);
    chk(rd, 32'h64);
    rdr(8'h40);
    chk(rsp, RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(rsp, RESP_SLVERR);
    smp(2);
    chk(sample_word, 32'h007f80ff);
    chk(duty_stabilized, 1'b1);
    rdr(OFS_STATUS);
    chk(rd, 32'h3);
    wr(OFS_CTRL, 32'h6);
    chk(rsp, RESP_OKAY);
    smp(2);
    chk(sample_word, 32'h80ff007f);
    wr(OFS_CTRL, 32'h406);
    smp(2);
    chk(sample_word, 32'h8000007f);
    wr(OFS_CTRL, 32'h44e);
    repeat (20) @(posedge aclk);
    chk(link_if.low_swing, 1'b1);
    chk(link_if.lane, 4'h0);
    wr(OFS_CTRL, 32'h446);
    smp(2);
    chk(sample_word, 32'h8000007f);
    wr(OFS_CTRL, 32'h447);
    repeat (10) @(posedge aclk);
    chk(link_if.link_oe, 1'b0);
    wr(OFS_CTRL, 32'h406);
    smp(2);
    chk(sample_word, 32'h8000007f);
    // Rate tests run in standby so an out-of-range rate stops no frame.
    wr(OFS_CTRL, 32'h43e);
    wr(OFS_RATE, 32'h5);
    repeat (10) @(posedge aclk);
    chk(rate_ok, 1'b1);
    chk(link_if.low_swing, 1'b1);
    chk(duty_stabilized, 1'b0);
    wr(OFS_CTRL, 32'h40e);
    repeat (10) @(posedge aclk);
    chk(rate_ok, 1'b0);
    wr(OFS_RATE, 32'h64);
    repeat (8) @(posedge aclk);
    chk(dcs_relocking, 1'b1);
    repeat (52) @(posedge aclk);
    chk(duty_stabilized, 1'b1);
    wr(OFS_CTRL, 32'h40c);
    repeat (10) @(posedge aclk);
    chk(duty_stabilized, 1'b0);
    print_verdict();
  end
endmodule
